// [src/acsp_port.sv]
// Three-wire serial configuration port with register file and strap fallback.
//
// How it works
// - Frame starts: select low, shift clock rises.
// - Bytes keep flowing while select stays low, until the count ends a counted frame.
// - Select high between bytes pauses counted frame, ends streaming one.
// - Select high at power-up: strap mode.
// - Select low later ends strap mode permanently.
// - Each frame opens with 16-bit instruction.
// - Two length bits set data byte count.
// - Data moves as 8-bit bytes.
// - Leading instruction bit selects read or write.
// - Read frame turns data pin to output.
// - MSB first by default, LSB by setting.
// - Data sampled on shift clock rising edge.
// - Clock, select inputs; data pin bidirectional.
// - Strap mode pins set format and stabilizer.
// - Map: config 00-02, transfer ff, functions 08-18; 01, 02 and ff are not decoded and read 00.
// - Reset loads documented default values.
// - Default phase gives shifted data clock.
// - Registers hold power, clock, offset, test, drive.
`timescale 1ns/100ps
`include "acsp_defines.svh"

module acsp_port (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_select_low_line_n,
  input wire logic i_shift_clock_or_format_pin,
  input wire logic i_data_or_stabilizer_pin,
  output logic o_data_or_stabilizer_pin,
  output logic o_data_or_stabilizer_pin_oe,
  output logic o_strap_mode,
  output logic o_strap_format,
  output logic o_duty_cycle_stabilizer,
  output acsp_pkg::acsp_regs_t o_regs
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  // Two flops per pin, plus a third on the shift clock; logic reads the second stage and that third flop for edges.
  logic [2:0] sync1, sync2;
  logic sclk_d;
  always_ff @(posedge i_sys_clk) begin
    sync1 <= {i_select_low_line_n, i_shift_clock_or_format_pin, i_data_or_stabilizer_pin};
    sync2 <= sync1;
    sclk_d <= sync2[1];
  end

  logic csb_n, sclk, sdi, sclk_rise, sclk_fall;
  assign csb_n = sync2[2];
  assign sclk = sync2[1];
  assign sdi = sync2[0];
  assign sclk_rise = sclk & ~sclk_d & ~csb_n;
  assign sclk_fall = ~sclk & sclk_d & ~csb_n;

  ////////////////////////////////////////////////////////////////////////////
  // Strap decision.

  // The first cycle after reset release reads the select pin; a reset never samples a port.
  logic strap, strap_known, next_strap, next_strap_known;
  always_comb begin
    next_strap = strap;
    next_strap_known = 1'b1;
    if (!strap_known) begin
      next_strap = csb_n;
    end else if (strap && !csb_n) begin
      next_strap = 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      strap <= 1'b0;
      strap_known <= 1'b0;
    end else begin
      strap <= next_strap;
      strap_known <= next_strap_known;
    end
  end

  // strap levels drive format and stabilizer
  logic strap_fmt, strap_dcs;
  always_ff @(posedge i_sys_clk) begin
    strap_fmt <= sclk;
    strap_dcs <= sdi;
  end
  assign o_strap_mode = strap & strap_known;
  assign o_strap_format = strap_fmt;
  assign o_duty_cycle_stabilizer = o_strap_mode ? strap_dcs : o_regs.clock[0];

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame engine.

  // Bit index within the byte, honouring the bit-order setting.
  function automatic logic [2:0] acsp_bitpos(input logic [2:0] cnt, input logic lsb_first);
    acsp_bitpos = lsb_first ? cnt : 3'h7 - cnt;
  endfunction

  acsp_pkg::acsp_state_t state, next_state;
  logic [15:0] instr, next_instr;
  logic [4:0] bitcnt, next_bitcnt;
  logic [7:0] addr, next_addr;
  logic [2:0] bytes_left, next_bytes_left;
  logic streaming, next_streaming;
  logic [7:0] shreg, next_shreg;
  logic rd, next_rd;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic lsb;
  logic [7:0] sdo_byte, next_sdo_byte;
  logic sdo, next_sdo;
  logic oe, next_oe;

  // bit order from the configuration register.
  assign lsb = o_regs.cfg[`ACSP_CFG_LSB_FIRST];
  assign wr_data = next_shreg;

  // Instruction and data shifting; select high pauses a counted frame and ends a streaming one.
  always_comb begin
    next_state = state;
    next_instr = instr;
    next_bitcnt = bitcnt;
    next_addr = addr;
    next_bytes_left = bytes_left;
    next_streaming = streaming;
    next_shreg = shreg;
    next_rd = rd;
    next_sdo_byte = sdo_byte;
    next_sdo = sdo;
    next_oe = oe;
    wr_stb = 1'b0;
    if (csb_n) begin
      next_oe = 1'b0;
    end
    case (state)
      acsp_pkg::ACSP_ST_IDLE: begin
        // frame opens on rising edge with select low
        if (sclk_rise && !strap) begin
          next_instr = {15'h0000, sdi};
          next_bitcnt = 5'd1;
          next_state = acsp_pkg::ACSP_ST_INSTR;
        end
      end
      acsp_pkg::ACSP_ST_INSTR: begin
        if (sclk_rise) begin
          next_instr = {instr[14:0], sdi};
          next_bitcnt = bitcnt + 5'd1;
          if (bitcnt == 5'(`ACSP_INSTR_BITS - 1)) begin
            next_rd = instr[`ACSP_INSTR_RW - 1];
            next_bytes_left = {1'b0, instr[`ACSP_INSTR_LEN_HI - 1], instr[`ACSP_INSTR_LEN_LO - 1]};
            next_streaming = instr[`ACSP_INSTR_LEN_HI - 1] & instr[`ACSP_INSTR_LEN_LO - 1];
            next_addr = {instr[6:0], sdi};
            next_bitcnt = 5'd0;
            next_state = acsp_pkg::ACSP_ST_DATA;
          end
        end
      end
      default: begin
        // a streaming frame has no count, so only a raised select can end it; a partial byte is dropped.
        if (csb_n && streaming) begin
          next_bitcnt = 5'd0;
          next_state = acsp_pkg::ACSP_ST_IDLE;
        end
        if (bitcnt == 5'd0 && rd) begin
          next_sdo_byte = rd_byte;
        end
        // drive pin on falling edge for reads
        if (sclk_fall && rd) begin
          next_oe = 1'b1;
          next_sdo = sdo_byte[acsp_bitpos(bitcnt[2:0], lsb)];
        end
        if (sclk_rise) begin
          next_shreg[acsp_bitpos(bitcnt[2:0], lsb)] = sdi;
          next_bitcnt = bitcnt + 5'd1;
          if (bitcnt == 5'(`ACSP_BYTE_BITS - 1)) begin
            // commit only on the eighth bit
            wr_stb = ~rd;
            next_bitcnt = 5'd0;
            next_addr = addr - 8'h01;
            if (!streaming) begin
              next_bytes_left = bytes_left - 3'h1;
              if (bytes_left == 3'h0) begin
                next_state = acsp_pkg::ACSP_ST_IDLE;
              end
            end
          end
        end
      end
    endcase
    if (strap) begin
      next_state = acsp_pkg::ACSP_ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state <= acsp_pkg::ACSP_ST_IDLE;
      instr <= 16'h0000;
      bitcnt <= 5'h00;
      addr <= 8'h00;
      bytes_left <= 3'h0;
      streaming <= 1'b0;
      shreg <= 8'h00;
      rd <= 1'b0;
      sdo_byte <= 8'h00;
      sdo <= 1'b0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      instr <= next_instr;
      bitcnt <= next_bitcnt;
      addr <= next_addr;
      bytes_left <= next_bytes_left;
      streaming <= next_streaming;
      shreg <= next_shreg;
      rd <= next_rd;
      sdo_byte <= next_sdo_byte;
      sdo <= next_sdo;
      oe <= next_oe;
    end
  end

  // data pin only driven during readback
  assign o_data_or_stabilizer_pin = sdo;
  assign o_data_or_stabilizer_pin_oe = oe & ~strap;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  always_comb begin
    if (addr == `ACSP_ADDR_CFG) begin
      rd_byte = o_regs.cfg;
    end else if (addr == `ACSP_ADDR_MODES) begin
      rd_byte = o_regs.modes;
    end else if (addr == `ACSP_ADDR_CLOCK) begin
      rd_byte = o_regs.clock;
    end else if (addr == `ACSP_ADDR_TEST) begin
      rd_byte = o_regs.test;
    end else if (addr == `ACSP_ADDR_OFFSET) begin
      rd_byte = o_regs.offset;
    end else if (addr == `ACSP_ADDR_OUTMODE) begin
      rd_byte = o_regs.outmode;
    end else if (addr == `ACSP_ADDR_PHASE) begin
      rd_byte = o_regs.phase;
    end else if (addr == `ACSP_ADDR_VREF) begin
      rd_byte = o_regs.vref;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // power, stabilizer, offset, test, drive, polarity registers
  acsp_pkg::acsp_regs_t next_regs;
  always_comb begin
    next_regs = o_regs;
    if (wr_stb) begin
      if (addr == `ACSP_ADDR_CFG) begin
        next_regs.cfg = wr_data;
      end else if (addr == `ACSP_ADDR_MODES) begin
        next_regs.modes = wr_data;
      end else if (addr == `ACSP_ADDR_CLOCK) begin
        next_regs.clock = wr_data;
      end else if (addr == `ACSP_ADDR_TEST) begin
        next_regs.test = wr_data;
      end else if (addr == `ACSP_ADDR_OFFSET) begin
        next_regs.offset = wr_data;
      end else if (addr == `ACSP_ADDR_OUTMODE) begin
        next_regs.outmode = wr_data & `ACSP_OUTMODE_MASK;
      end else if (addr == `ACSP_ADDR_PHASE) begin
        next_regs.phase = wr_data;
      end else if (addr == `ACSP_ADDR_VREF) begin
        next_regs.vref = wr_data;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_regs.cfg <= `ACSP_RST_CFG;
      o_regs.modes <= `ACSP_RST_MODES;
      o_regs.clock <= `ACSP_RST_CLOCK;
      o_regs.test <= `ACSP_RST_TEST;
      o_regs.offset <= `ACSP_RST_OFFSET;
      // phase default zero means ninety degree shift
      o_regs.outmode <= `ACSP_RST_OUTMODE;
      o_regs.phase <= `ACSP_RST_PHASE;
      o_regs.vref <= `ACSP_RST_VREF;
    end else begin
      o_regs <= next_regs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  // output enable only in a read frame.
  a_oe_read_only: assert property (@(posedge i_sys_clk) disable iff (i_rst) oe |-> rd)
    else $error("Data pin driven outside readback.");
  a_strap_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (strap_known && !strap) |=> !strap) else $error("Strap mode re-entered.");
  // writes only in data phase with write frame.
  a_write_phase: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_stb |-> (state == acsp_pkg::ACSP_ST_DATA && !rd && sclk_rise)) else $error("Stray register write.");
  // open bits of output mode stay clear.
  a_open_bits: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_regs.outmode & ~`ACSP_OUTMODE_MASK) == 8'h00) else $error("Open bits set.");
  // the sixteenth instruction bit opens the data phase at bit zero.
  sequence s_instr_done;
    state == acsp_pkg::ACSP_ST_INSTR && sclk_rise && bitcnt == 5'(`ACSP_INSTR_BITS - 1);
  endsequence
  a_instr_done: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    s_instr_done |=> (state == acsp_pkg::ACSP_ST_DATA && bitcnt == 5'd0)) else $error("Instruction phase not closed.");
  // select high at the decision cycle gives strap mode.
  a_strap_entry: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!strap_known && csb_n) |=> o_strap_mode) else $error("Strap mode not entered.");
  // a raised select releases the data pin.
  a_pause_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    csb_n |=> !o_data_or_stabilizer_pin_oe) else $error("Data pin driven while deselected.");
endmodule

// [shared/acsp_defines.svh]
// Register offsets, reset values, field positions and counts of the serial configuration port.
`ifndef ACSP_DEFINES_SVH
`define ACSP_DEFINES_SVH
`define ACSP_ADDR_CFG 8'h00
`define ACSP_ADDR_ID 8'h01
`define ACSP_ADDR_GRADE 8'h02
`define ACSP_ADDR_XFER 8'hff
`define ACSP_ADDR_MODES 8'h08
`define ACSP_ADDR_CLOCK 8'h09
`define ACSP_ADDR_TEST 8'h0d
`define ACSP_ADDR_OFFSET 8'h10
`define ACSP_ADDR_OUTMODE 8'h14
`define ACSP_ADDR_PHASE 8'h16
`define ACSP_ADDR_VREF 8'h18
`define ACSP_RST_CFG 8'h18
`define ACSP_RST_MODES 8'h00
`define ACSP_RST_CLOCK 8'h01
`define ACSP_RST_TEST 8'h00
`define ACSP_RST_OFFSET 8'h00
`define ACSP_RST_OUTMODE 8'h00
`define ACSP_RST_PHASE 8'h00
`define ACSP_RST_VREF 8'h00
`define ACSP_CFG_LSB_FIRST 6
`define ACSP_OUTMODE_MASK 8'h1f
`define ACSP_INSTR_BITS 16
`define ACSP_BYTE_BITS 8
`define ACSP_INSTR_RW 15
`define ACSP_INSTR_LEN_HI 14
`define ACSP_INSTR_LEN_LO 13
`endif

// [shared/acsp_pkg.sv]
// Types shared by the serial configuration port.
package acsp_pkg;
  typedef enum logic [1:0] {
    ACSP_ST_IDLE,
    ACSP_ST_INSTR,
    ACSP_ST_DATA
  } acsp_state_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] modes;
    logic [7:0] clock;
    logic [7:0] test;
    logic [7:0] offset;
    logic [7:0] outmode;
    logic [7:0] phase;
    logic [7:0] vref;
  } acsp_regs_t;
endpackage

// [test/acsp_host.sv]
// Host controller model that frames transfers on the serial configuration port.
`timescale 1ns/100ps
module acsp_host (
  input wire logic i_dev_d,
  input wire logic i_dev_oe,
  output logic o_sel_n,
  output logic o_sclk,
  output logic o_pin,
  output logic o_clash,
  output logic o_paused
);
  logic drv;
  logic hd;

  // Idle: deselected, link clock standing still, line driven high.
  initial begin
    o_sel_n = 1'b1;
    o_sclk = 1'b0;
    o_clash = 1'b0;
    o_paused = 1'b0;
    drv = 1'b1;
    hd = 1'b1;
  end

  // The wire carries whoever drives it; a released line shows the inverse of its last level.
  assign o_pin = i_dev_oe ? i_dev_d : hd;
  always @(negedge i_dev_oe) begin
    if (!drv) hd = ~i_dev_d;
  end

  // Both ends driving at once would be a direction fault.
  always @(posedge i_dev_oe) begin
    if (drv) o_clash = 1'b1;
  end

  task automatic clk_bit(input logic b, output logic r);
    if (drv) hd = b;
    #62.5;
    r = o_pin;
    o_sclk = 1'b1;
    #62.5;
    o_sclk = 1'b0;
  endtask

  task automatic strap(input logic fmt, input logic duty_cycle_stabilizer);
    o_sclk = fmt;
    hd = duty_cycle_stabilizer;
  endtask

  task automatic xfer(input logic rd, input logic [1:0] len, input logic [7:0] addr, input int n,
      input logic lsb, input int pause, input logic [31:0] wd, output logic [31:0] rdat);
    logic [15:0] ins;
    logic r;
    int p;
    ins = {rd, len, 5'h00, addr};
    rdat = 32'h0;
    o_sel_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      clk_bit(ins[i], r);
    end
    if (rd) begin
      drv = 1'b0;
      hd = ~hd;
    end
    for (int k = 0; k < n; k++) begin
      if (k == pause) begin
        o_sel_n = 1'b1;
        o_paused = 1'b1;
        #500;
        o_paused = 1'b0;
        o_sel_n = 1'b0;
      end
      for (int j = 0; j < 8; j++) begin
        p = 8 * k + (lsb ? j : 7 - j);
        clk_bit(wd[p], r);
        rdat[p] = r;
      end
    end
    #62.5;
    o_sel_n = 1'b1;
    drv = 1'b1;
  endtask
endmodule

// [test/tb.sv]
// Self-checking bench for the serial configuration port.
`timescale 1ns/100ps
`include "acsp_defines.svh"
module tb;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sel_n, sclk, pin, dev_d, dev_oe, clash, paused, smode, sfmt, duty_cycle_stabilizer;
  acsp_pkg::acsp_regs_t regs;
  logic [31:0] rdat;
  int fail_count = 0;
  int total_checks = 0;

  // Free-running system clock.
  always #2 i_sys_clk = ~i_sys_clk;

  acsp_port u_acsp_port (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_select_low_line_n(sel_n),
    .i_shift_clock_or_format_pin(sclk), .i_data_or_stabilizer_pin(pin), .o_data_or_stabilizer_pin(dev_d),
    .o_data_or_stabilizer_pin_oe(dev_oe), .o_strap_mode(smode), .o_strap_format(sfmt),
    .o_duty_cycle_stabilizer(duty_cycle_stabilizer), .o_regs(regs));
  acsp_host u_acsp_host (.i_dev_d(dev_d), .i_dev_oe(dev_oe), .o_sel_n(sel_n), .o_sclk(sclk), .o_pin(pin),
    .o_clash(clash), .o_paused(paused));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, frame helpers and the closing report.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Frames start off both clock edges so link and system edges never coincide.
  task automatic fr(input logic rd, input logic [1:0] len, input logic [7:0] addr, input int n,
      input logic lsb, input int pause, input logic [31:0] wd);
    @(negedge i_sys_clk);
    #1.25;
    u_acsp_host.xfer(rd, len, addr, n, lsb, pause, wd, rdat);
    repeat (8) @(negedge i_sys_clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: strap start, then frames of every length and order.
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_sys_clk);
    chk(regs.cfg, `ACSP_RST_CFG);
    chk(regs.clock, `ACSP_RST_CLOCK);
    chk(regs.phase, `ACSP_RST_PHASE);
    chk(regs.test, `ACSP_RST_TEST);
    chk({7'h0, smode}, 8'h01);
    for (int v = 1; v >= 0; v--) begin
      u_acsp_host.strap(v[0], ~v[0]);
      repeat (10) @(negedge i_sys_clk);
      chk({6'h0, sfmt, duty_cycle_stabilizer}, {6'h0, v[0], ~v[0]});
    end
    fr(1'b1, 2'd0, 8'h00, 1, 1'b0, 9, 32'h0);
    chk(rdat[7:0], 8'h18);
    chk({7'h0, smode}, 8'h00);
    fr(1'b1, 2'd0, 8'h13, 1, 1'b0, 9, 32'h0);
    chk(rdat[7:0], 8'h00);
    fr(1'b0, 2'd0, 8'h14, 1, 1'b0, 9, 32'h0000_001f);
    chk(regs.outmode, 8'h1f);
    // A stall between bytes must commit the first byte only.
    fork
      fr(1'b0, 2'd1, 8'h09, 2, 1'b0, 1, 32'h0000_0302);
      begin
        @(posedge paused);
        #100;
        chk(regs.clock, 8'h02);
        chk(regs.modes, 8'h00);
      end
    join
    chk(regs.modes, 8'h03);
    chk({7'h0, duty_cycle_stabilizer}, 8'h00);
    fr(1'b0, 2'd3, 8'h18, 4, 1'b0, 9, 32'h005a_003c);
    chk(regs.vref, 8'h3c);
    chk(regs.phase, 8'h5a);
    fr(1'b1, 2'd2, 8'h16, 3, 1'b0, 9, 32'h0);
    chk(rdat[7:0], 8'h5a);
    chk(rdat[15:8], 8'h00);
    chk(rdat[23:16], 8'h1f);
    fr(1'b0, 2'd0, 8'h00, 1, 1'b0, 9, 32'h0000_0058);
    fr(1'b0, 2'd0, 8'h10, 1, 1'b1, 9, 32'h0000_0001);
    chk(regs.offset, 8'h01);
    fr(1'b1, 2'd0, 8'h10, 1, 1'b1, 9, 32'h0);
    chk(rdat[7:0], 8'h01);
    fr(1'b0, 2'd0, 8'h00, 1, 1'b1, 9, 32'h0000_0018);
    chk(regs.cfg, 8'h18);
    chk({6'h0, clash, dev_oe}, 8'h00);
    give_verdict();
  end

  // Watchdog: the frames need about 40 us, so this span means a hang.
  initial begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: run did not finish", $time);
    give_verdict();
  end
endmodule
